// file: src/operand_addressing_unit.sv
`default_nettype none
// Summary of operation
// - Immediate mode writes A, F, SP or X
// - Immediate operand is source; opcode names second
// - Every instruction here is opcode plus operand
// - Direct mode reads RAM or register operand
// - Direct/indexed result to A or X
// - Indexed address is operand plus X
// - Destination direct writes memory, register unchanged
// - Indirect load reads pointer, then data to A
// - Pointer incremented after transfer uses old value
// - Indirect modes only with move indirect
// - Indirect store writes A through pointer
// - X register holds the index offset
// - Flags bit 4 selects register bank
module operand_addressing_unit (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // Program memory byte stream
    input  wire logic                 prog_valid,
    input  wire logic [7:0]           prog_byte,
    output logic                      prog_ready,
    // Data RAM and register space
    output opaddr_pkg::mem_req_s      mem_req,
    input  wire logic                 mem_ack,
    input  wire logic [7:0]           mem_rdata,
    // Core state seen by the rest of the core
    output logic [7:0]                acc,
    output logic [7:0]                idx,
    output logic [7:0]                stack_pointer,
    output logic [7:0]                flags,
    output logic                      busy,
    output logic                      illegal_op
);
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_OPERAND,
        ST_READ,
        ST_PTR_DATA,
        ST_WRITE,
        ST_PTR_WB
    } state_e;

    state_e               state_ff, nxt_state;
    logic [7:0]           opcode_ff;
    logic [7:0]           operand_ff;
    logic [7:0]           ptr_ff;
    logic [7:0]           acc_ff, idx_ff, sp_ff, flags_ff;
    logic                 illegal_ff;
    logic                 ready_ff;
    logic                 busy_ff;
    opaddr_pkg::mem_req_s req_ff, nxt_req;

    function automatic opaddr_pkg::decode_s decode(input logic [7:0] op);
        opaddr_pkg::decode_s d;
        d = '{mode: opaddr_pkg::MODE_NONE, tgt: opaddr_pkg::TGT_ACC,
              alu: opaddr_pkg::ALU_PASS, reg_space: 1'b0, valid: 1'b0};
        case (op)
            opaddr_pkg::OP_ADD_A_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_ADD,  1'b0, 1'b1};
            opaddr_pkg::OP_SUB_A_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_SUB,  1'b0, 1'b1};
            opaddr_pkg::OP_XOR_A_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_XOR,  1'b0, 1'b1};
            opaddr_pkg::OP_MOV_A_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_X_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_IDX,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_ADD_SP_IMM: d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_SP,    opaddr_pkg::ALU_ADD,  1'b0, 1'b1};
            opaddr_pkg::OP_AND_F_IMM:  d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_FLAGS, opaddr_pkg::ALU_AND,  1'b0, 1'b1};
            opaddr_pkg::OP_OR_F_IMM:   d = '{opaddr_pkg::MODE_SRC_IMM, opaddr_pkg::TGT_FLAGS, opaddr_pkg::ALU_OR,   1'b0, 1'b1};
            opaddr_pkg::OP_ADD_A_DIR:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_ADD,  1'b0, 1'b1};
            opaddr_pkg::OP_SUB_A_DIR:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_SUB,  1'b0, 1'b1};
            opaddr_pkg::OP_XOR_A_DIR:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_XOR,  1'b0, 1'b1};
            opaddr_pkg::OP_MOV_A_DIR:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_X_DIR:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_IDX,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_A_REG:  d = '{opaddr_pkg::MODE_SRC_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b1, 1'b1};
            opaddr_pkg::OP_ADD_A_IDX:  d = '{opaddr_pkg::MODE_SRC_IDX, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_ADD,  1'b0, 1'b1};
            opaddr_pkg::OP_SUB_A_IDX:  d = '{opaddr_pkg::MODE_SRC_IDX, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_SUB,  1'b0, 1'b1};
            opaddr_pkg::OP_XOR_A_IDX:  d = '{opaddr_pkg::MODE_SRC_IDX, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_XOR,  1'b0, 1'b1};
            opaddr_pkg::OP_MOV_A_IDX:  d = '{opaddr_pkg::MODE_SRC_IDX, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_A_REGX: d = '{opaddr_pkg::MODE_SRC_IDX, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b1, 1'b1};
            opaddr_pkg::OP_ADD_DIR_A:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_ADD,  1'b0, 1'b1};
            opaddr_pkg::OP_SUB_DIR_A:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_SUB,  1'b0, 1'b1};
            opaddr_pkg::OP_XOR_DIR_A:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_XOR,  1'b0, 1'b1};
            opaddr_pkg::OP_MOV_DIR_A:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_DIR_X:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_IDX,   opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MOV_REG_A:  d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b1, 1'b1};
            opaddr_pkg::OP_MOV_REGX_A: d = '{opaddr_pkg::MODE_DST_DIR, opaddr_pkg::TGT_ACC,   opaddr_pkg::ALU_PASS, 1'b1, 1'b1};
            // Only the move-indirect opcodes reach the pointer modes
            opaddr_pkg::OP_MVI_LOAD:   d = '{opaddr_pkg::MODE_SRC_IND_INC, opaddr_pkg::TGT_ACC, opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            opaddr_pkg::OP_MVI_STORE:  d = '{opaddr_pkg::MODE_DST_IND_INC, opaddr_pkg::TGT_MEM, opaddr_pkg::ALU_PASS, 1'b0, 1'b1};
            default:                   d.valid = 1'b0;
        endcase
        return d;
    endfunction

    function automatic logic [7:0] alu(input opaddr_pkg::alu_op_e op, input logic [7:0] a, input logic [7:0] b);
        case (op)
            opaddr_pkg::ALU_ADD: alu = 8'(a + b);
            opaddr_pkg::ALU_SUB: alu = 8'(a - b);
            opaddr_pkg::ALU_XOR: alu = a ^ b;
            opaddr_pkg::ALU_AND: alu = a & b;
            opaddr_pkg::ALU_OR:  alu = a | b;
            default:             alu = b;
        endcase
    endfunction

    opaddr_pkg::decode_s dec;
    logic [7:0]          reg_sel;
    logic [7:0]          idx_addr;
    logic [7:0]          imm_result;
    logic [7:0]          src_result;
    logic [7:0]          dst_result;
    logic [7:0]          ptr_inc;
    logic                is_indexed_op;
    logic                bank;

    assign dec           = decode(opcode_ff);
    // Second source / destination register named by the opcode
    assign reg_sel       = (dec.tgt == opaddr_pkg::TGT_IDX)   ? idx_ff :
                           (dec.tgt == opaddr_pkg::TGT_SP)    ? sp_ff  :
                           (dec.tgt == opaddr_pkg::TGT_FLAGS) ? flags_ff : acc_ff;
    assign is_indexed_op = (dec.mode == opaddr_pkg::MODE_SRC_IDX) || (opcode_ff == opaddr_pkg::OP_ADD_IDX_A)
                           || (opcode_ff == opaddr_pkg::OP_MOV_REGX_A);
    assign idx_addr      = 8'(operand_ff + idx_ff);
    assign imm_result    = alu(dec.alu, reg_sel, operand_ff);
    assign src_result    = alu(dec.alu, reg_sel, mem_rdata);
    assign dst_result    = alu(dec.alu, mem_rdata, reg_sel);
    assign ptr_inc       = 8'(ptr_ff + 8'h01);
    assign bank          = flags_ff[opaddr_pkg::FLAG_BANK_BIT];

    always_comb begin
        nxt_state = state_ff;
        nxt_req   = req_ff;
        case (state_ff)
            ST_OPCODE: begin
                if (prog_valid) begin
                    nxt_state = ST_OPERAND;
                end
            end
            ST_OPERAND: begin
                if (prog_valid) begin
                    nxt_state     = ST_READ;
                    nxt_req       = '0;
                    nxt_req.rd    = 1'b1;
                    nxt_req.bank  = bank;
                    nxt_req.reg_space = dec.reg_space;
                    nxt_req.addr  = is_indexed_op ? 8'(prog_byte + idx_ff) : prog_byte;
                    if (!dec.valid || dec.mode == opaddr_pkg::MODE_SRC_IMM) begin
                        nxt_state = ST_OPCODE;
                        nxt_req   = '0;
                    end else if (dec.mode == opaddr_pkg::MODE_DST_DIR && dec.alu == opaddr_pkg::ALU_PASS) begin
                        // Plain moves skip the read of the destination
                        nxt_state    = ST_OPCODE;
                        nxt_req.rd   = 1'b0;
                        nxt_req.wr   = 1'b1;
                        nxt_req.wdata = reg_sel;
                        nxt_state    = ST_WRITE;
                    end
                end
            end
            ST_READ: begin
                if (mem_ack) begin
                    nxt_req.rd = 1'b0;
                    case (dec.mode)
                        opaddr_pkg::MODE_DST_DIR: begin
                            nxt_state     = ST_WRITE;
                            nxt_req.wr    = 1'b1;
                            nxt_req.wdata = dst_result;
                        end
                        opaddr_pkg::MODE_SRC_IND_INC: begin
                            nxt_state     = ST_PTR_DATA;
                            nxt_req.rd    = 1'b1;
                            nxt_req.reg_space = 1'b0;
                            nxt_req.addr  = mem_rdata;
                        end
                        opaddr_pkg::MODE_DST_IND_INC: begin
                            nxt_state     = ST_PTR_DATA;
                            nxt_req.wr    = 1'b1;
                            nxt_req.reg_space = 1'b0;
                            nxt_req.addr  = mem_rdata;
                            nxt_req.wdata = acc_ff;
                        end
                        default: nxt_state = ST_OPCODE;
                    endcase
                end
            end
            ST_PTR_DATA: begin
                if (mem_ack) begin
                    // Pointer bumped only after the data move used its old value
                    nxt_state     = ST_PTR_WB;
                    nxt_req.rd    = 1'b0;
                    nxt_req.wr    = 1'b1;
                    nxt_req.addr  = operand_ff;
                    nxt_req.wdata = ptr_inc;
                end
            end
            ST_WRITE, ST_PTR_WB: begin
                if (mem_ack) begin
                    nxt_state = ST_OPCODE;
                    nxt_req   = '0;
                end
            end
            default: nxt_state = ST_OPCODE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff   <= ST_OPCODE;
            req_ff     <= '0;
            opcode_ff  <= opaddr_pkg::REG_RESET;
            operand_ff <= opaddr_pkg::REG_RESET;
            ptr_ff     <= opaddr_pkg::REG_RESET;
            illegal_ff <= 1'b0;
            ready_ff   <= 1'b1;
            busy_ff    <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            req_ff   <= nxt_req;
            // Status outputs registered from the next state, so they track state_ff exactly
            ready_ff <= (nxt_state == ST_OPCODE) || (nxt_state == ST_OPERAND);
            busy_ff  <= (nxt_state != ST_OPCODE);
            if (state_ff == ST_OPCODE && prog_valid) begin
                opcode_ff <= prog_byte;
            end
            if (state_ff == ST_OPERAND && prog_valid) begin
                operand_ff <= prog_byte;
                illegal_ff <= !dec.valid;
            end
            if (state_ff == ST_READ && mem_ack) begin
                ptr_ff <= mem_rdata;
            end
        end
    end

    // Architectural registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_ff   <= opaddr_pkg::REG_RESET;
            idx_ff   <= opaddr_pkg::REG_RESET;
            sp_ff    <= opaddr_pkg::REG_RESET;
            flags_ff <= opaddr_pkg::FLAGS_RESET;
        end else if (clk_en) begin
            if (state_ff == ST_OPERAND && prog_valid && dec.valid && dec.mode == opaddr_pkg::MODE_SRC_IMM) begin
                case (dec.tgt)
                    opaddr_pkg::TGT_IDX:   idx_ff <= alu(dec.alu, reg_sel, prog_byte);
                    opaddr_pkg::TGT_SP:    sp_ff  <= alu(dec.alu, reg_sel, prog_byte);
                    opaddr_pkg::TGT_FLAGS: flags_ff <= alu(dec.alu, reg_sel, prog_byte) & opaddr_pkg::FLAGS_WR_MASK;
                    default:               acc_ff <= alu(dec.alu, reg_sel, prog_byte);
                endcase
            end
            if (state_ff == ST_READ && mem_ack
                && (dec.mode == opaddr_pkg::MODE_SRC_DIR || dec.mode == opaddr_pkg::MODE_SRC_IDX)) begin
                if (dec.tgt == opaddr_pkg::TGT_IDX) begin
                    idx_ff <= src_result;
                end else begin
                    acc_ff <= src_result;
                end
            end
            if (state_ff == ST_PTR_DATA && mem_ack && dec.mode == opaddr_pkg::MODE_SRC_IND_INC) begin
                acc_ff <= mem_rdata;
            end
        end
    end

    assign prog_ready    = ready_ff;
    assign mem_req       = req_ff;
    assign acc           = acc_ff;
    assign idx           = idx_ff;
    assign stack_pointer = sp_ff;
    assign flags         = flags_ff;
    assign busy          = busy_ff;
    assign illegal_op    = illegal_ff;
endmodule
`default_nettype wire

// file: src/opaddr_pkg.sv
`default_nettype none
package opaddr_pkg;
    // Opcodes of this unit (two-byte forms only); OP_ADD_IDX_A is defined but decodes as illegal
    localparam logic [7:0] OP_ADD_A_IMM   = 8'h01;
    localparam logic [7:0] OP_ADD_A_DIR   = 8'h02;
    localparam logic [7:0] OP_ADD_A_IDX   = 8'h03;
    localparam logic [7:0] OP_ADD_DIR_A   = 8'h04;
    localparam logic [7:0] OP_ADD_IDX_A   = 8'h05;
    localparam logic [7:0] OP_SUB_A_IMM   = 8'h11;
    localparam logic [7:0] OP_SUB_A_DIR   = 8'h12;
    localparam logic [7:0] OP_SUB_A_IDX   = 8'h13;
    localparam logic [7:0] OP_SUB_DIR_A   = 8'h14;
    localparam logic [7:0] OP_XOR_A_IMM   = 8'h31;
    localparam logic [7:0] OP_XOR_A_DIR   = 8'h32;
    localparam logic [7:0] OP_XOR_A_IDX   = 8'h33;
    localparam logic [7:0] OP_XOR_DIR_A   = 8'h34;
    localparam logic [7:0] OP_ADD_SP_IMM  = 8'h38;
    localparam logic [7:0] OP_MVI_LOAD    = 8'h3E;
    localparam logic [7:0] OP_MVI_STORE   = 8'h3F;
    localparam logic [7:0] OP_MOV_DIR_X   = 8'h5A;
    localparam logic [7:0] OP_MOV_A_REG   = 8'h5D;
    localparam logic [7:0] OP_MOV_A_REGX  = 8'h5E;
    localparam logic [7:0] OP_MOV_REG_A   = 8'h60;
    localparam logic [7:0] OP_MOV_REGX_A  = 8'h61;
    localparam logic [7:0] OP_MOV_X_IMM   = 8'h57;
    localparam logic [7:0] OP_MOV_A_IMM   = 8'h50;
    localparam logic [7:0] OP_MOV_A_DIR   = 8'h51;
    localparam logic [7:0] OP_MOV_A_IDX   = 8'h52;
    localparam logic [7:0] OP_MOV_X_DIR   = 8'h58;
    localparam logic [7:0] OP_MOV_DIR_A   = 8'h53;
    localparam logic [7:0] OP_AND_F_IMM   = 8'h70;
    localparam logic [7:0] OP_OR_F_IMM    = 8'h71;

    // Flags register layout
    localparam int           FLAG_BANK_BIT  = 4;
    localparam logic [7:0]   FLAGS_RESET    = 8'h02;
    localparam logic [7:0]   FLAGS_WR_MASK  = 8'h17;
    localparam logic [7:0]   REG_RESET      = 8'h00;

    typedef enum logic [2:0] {
        MODE_SRC_IMM,
        MODE_SRC_DIR,
        MODE_SRC_IDX,
        MODE_DST_DIR,
        MODE_SRC_IND_INC,
        MODE_DST_IND_INC,
        MODE_NONE
    } addr_mode_e;

    typedef enum logic [2:0] {
        TGT_ACC,
        TGT_IDX,
        TGT_SP,
        TGT_FLAGS,
        TGT_MEM
    } target_e;

    typedef enum logic [2:0] {
        ALU_PASS,
        ALU_ADD,
        ALU_SUB,
        ALU_XOR,
        ALU_AND,
        ALU_OR
    } alu_op_e;

    typedef struct packed {
        addr_mode_e mode;
        target_e    tgt;
        alu_op_e    alu;
        logic       reg_space;
        logic       valid;
    } decode_s;

    // One memory request toward RAM or register space
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       reg_space;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;
endpackage
`default_nettype wire

// file: bench/oau_properties.sv
`default_nettype none
module oau_properties (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // Program stream
    input wire logic                 clk_en,
    input wire logic                 prog_valid,
    input wire logic [7:0]           prog_byte,
    input wire logic                 prog_ready,
    // Memory side
    input wire opaddr_pkg::mem_req_s mem_req,
    input wire logic                 mem_ack,
    // Core state
    input wire logic [7:0]           acc,
    input wire logic [7:0]           idx,
    input wire logic [7:0]           stack_pointer,
    input wire logic [7:0]           flags
);
    logic       tk;
    logic       opd;
    logic       ph_ff;
    logic [7:0] op_ff;
    logic [7:0] arg_ff;
    logic       req;
    assign tk  = clk_en && prog_valid && prog_ready;
    assign opd = tk && ph_ff;
    assign req = mem_req.rd || mem_req.wr;
    // Byte parity tells opcode from operand, since a byte value alone cannot
    always_ff @(posedge clk) begin
        if (!rst_n) ph_ff <= 1'b0;
        else if (tk) ph_ff <= ~ph_ff;
    end
    always_ff @(posedge clk) begin
        if (tk && !ph_ff) op_ff <= prog_byte;
        if (opd) arg_ff <= prog_byte;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_req_held: assert property (req && !mem_ack |=> $stable(mem_req))
        else $error("memory request changed before its ack");
    a_one_dir: assert property (!(mem_req.rd && mem_req.wr))
        else $error("read and write requested together");
    a_bank_flag: assert property (req && mem_req.reg_space |-> mem_req.bank == flags[4])
        else $error("register bank differs from flags bit 4");
    a_flags_fixed: assert property ((flags & 8'hE8) == 8'h00)
        else $error("read-only flags bits changed");
    a_ready_low: assert property (req |-> !prog_ready)
        else $error("program stream ready during memory cycle");
    a_imm_acc: assert property (opd && op_ff == opaddr_pkg::OP_MOV_A_IMM |=> acc == $past(prog_byte))
        else $error("immediate load missed accumulator");
    a_imm_idx: assert property (opd && op_ff == opaddr_pkg::OP_MOV_X_IMM |=> idx == $past(prog_byte))
        else $error("immediate load missed index register");
    a_sp_add: assert property (opd && op_ff == opaddr_pkg::OP_ADD_SP_IMM
        |=> stack_pointer == $past(stack_pointer) + $past(prog_byte))
        else $error("stack pointer add wrong");
    a_and_flags: assert property (opd && op_ff == opaddr_pkg::OP_AND_F_IMM
        |=> flags == ($past(flags) & ($past(prog_byte) | 8'hE8)))
        else $error("flags and wrong");
    a_dir_addr: assert property (opd && op_ff == opaddr_pkg::OP_MOV_A_DIR
        |-> ##[1:2] (mem_req.rd && !mem_req.reg_space && mem_req.addr == arg_ff))
        else $error("direct read address wrong");
    a_idx_addr: assert property (opd && op_ff == opaddr_pkg::OP_MOV_A_IDX
        |-> ##[1:2] (mem_req.rd && mem_req.addr == 8'(arg_ff + idx)))
        else $error("indexed read address wrong");
    a_reg_space: assert property (opd && op_ff == opaddr_pkg::OP_MOV_A_REG
        |-> ##[1:2] (mem_req.rd && mem_req.reg_space && mem_req.addr == arg_ff))
        else $error("register space read wrong");
endmodule
bind operand_addressing_unit oau_properties oau_properties_inst (.clk, .rst_n, .clk_en, .prog_valid,
    .prog_byte, .prog_ready, .mem_req, .mem_ack, .acc, .idx, .stack_pointer, .flags);
`default_nettype wire

// file: bench/mem_model.sv
`default_nettype none
module mem_model (
    // Clock
    input  wire logic                 clk,
    // Request and answer
    input  wire opaddr_pkg::mem_req_s mem_req,
    output logic                      mem_ack,
    output logic [7:0]                mem_rdata,
    // Answer delay in cycles
    input  wire logic [3:0]           delay
);
    logic [7:0] ram [256];
    logic [7:0] regs [2][256];
    logic [7:0] last_ff = 8'h00;
    logic [3:0] wait_ff = 4'h0;
    logic       pend;
    logic [7:0] rd_val;
    assign pend    = mem_req.rd || mem_req.wr;
    assign mem_ack = pend && wait_ff >= delay;
    assign rd_val  = mem_req.reg_space ? regs[mem_req.bank][mem_req.addr] : ram[mem_req.addr];
    // Read data only with the ack; otherwise a flipping pattern so stale data never looks valid
    assign mem_rdata = (mem_ack && mem_req.rd) ? rd_val : ~last_ff;
    always @(posedge clk) begin
        wait_ff <= (mem_ack || !pend) ? 4'h0 : wait_ff + 4'h1;
        last_ff <= mem_rdata;
        if (mem_ack && mem_req.wr && mem_req.reg_space) regs[mem_req.bank][mem_req.addr] <= mem_req.wdata;
        if (mem_ack && mem_req.wr && !mem_req.reg_space) ram[mem_req.addr] <= mem_req.wdata;
    end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 clk_en = 1'b1;
    logic                 prog_valid = 1'b0;
    logic [7:0]           prog_byte = 8'h00;
    logic [3:0]           delay = 4'h0;
    logic                 prog_ready, mem_ack, busy, illegal_op;
    logic [7:0]           mem_rdata, acc, idx, stack_pointer, flags;
    opaddr_pkg::mem_req_s mem_req;
    int                   err_total = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;
    always #5 clk = ~clk;
    operand_addressing_unit operand_addressing_unit_inst (.clk, .rst_n, .clk_en, .prog_valid, .prog_byte,
        .prog_ready, .mem_req, .mem_ack, .mem_rdata, .acc, .idx, .stack_pointer, .flags, .busy, .illegal_op);
    mem_model mem_model_inst (.clk, .mem_req, .mem_ack, .mem_rdata, .delay);
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk);
        prog_valid = 1'b1;
        prog_byte  = b;
        do begin
            @(posedge clk);
            n++;
        end while (!(prog_ready && clk_en) && n < 100);
    endtask
    task automatic run(input logic [7:0] op, input logic [7:0] arg);
        int n;
        n = 0;
        put(op);
        put(arg);
        @(negedge clk);
        prog_valid = 1'b0;
        while ((busy || !prog_ready) && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_imm();
        put(opaddr_pkg::OP_MOV_A_IMM);
        put(8'h21);
        put(opaddr_pkg::OP_ADD_A_IMM);
        put(8'h14);
        put(opaddr_pkg::OP_SUB_A_IMM);
        put(8'h05);
        run(opaddr_pkg::OP_XOR_A_IMM, 8'hFF);
        chk(acc, 8'hCF);
        run(opaddr_pkg::OP_MOV_X_IMM, 8'h10);
        chk(idx, 8'h10);
        run(opaddr_pkg::OP_ADD_SP_IMM, 8'hFE);
        run(opaddr_pkg::OP_ADD_SP_IMM, 8'h03);
        chk(stack_pointer, 8'h01);
        run(opaddr_pkg::OP_OR_F_IMM, 8'hFF);
        chk(flags, 8'h17);
        run(opaddr_pkg::OP_AND_F_IMM, 8'hEF);
        chk(flags, 8'h07);
    endtask
    task automatic t_dir();
        delay = 4'h3;
        mem_model_inst.ram[8'h40] = 8'h11;
        mem_model_inst.ram[8'h50] = 8'h22;
        mem_model_inst.ram[8'h01] = 8'h5C;
        run(opaddr_pkg::OP_MOV_A_DIR, 8'h40);
        chk(acc, 8'h11);
        run(opaddr_pkg::OP_ADD_A_DIR, 8'h50);
        chk(acc, 8'h33);
        run(opaddr_pkg::OP_MOV_X_DIR, 8'h40);
        chk(idx, 8'h11);
        run(opaddr_pkg::OP_MOV_A_IDX, 8'h3F);
        chk(acc, 8'h22);
        run(opaddr_pkg::OP_MOV_A_IDX, 8'hF0);
        chk(acc, 8'h5C);
    endtask
    task automatic t_dst();
        delay = 4'h1;
        run(opaddr_pkg::OP_ADD_DIR_A, 8'h40);
        chk(mem_model_inst.ram[8'h40], 8'h6D);
        chk(acc, 8'h5C);
        run(opaddr_pkg::OP_XOR_DIR_A, 8'h40);
        chk(mem_model_inst.ram[8'h40], 8'h31);
        run(opaddr_pkg::OP_MOV_DIR_X, 8'h61);
        chk(mem_model_inst.ram[8'h61], 8'h11);
    endtask
    task automatic t_reg();
        delay = 4'h2;
        mem_model_inst.regs[0][8] = 8'h99;
        mem_model_inst.regs[1][9] = 8'hA5;
        run(opaddr_pkg::OP_OR_F_IMM, 8'h10);
        run(opaddr_pkg::OP_MOV_REG_A, 8'h08);
        chk(mem_model_inst.regs[1][8], 8'h5C);
        chk(mem_model_inst.regs[0][8], 8'h99);
        run(opaddr_pkg::OP_MOV_A_REGX, 8'hF8);
        chk(acc, 8'hA5);
        run(opaddr_pkg::OP_AND_F_IMM, 8'hEF);
        run(opaddr_pkg::OP_MOV_A_REG, 8'h08);
        chk(acc, 8'h99);
    endtask
    task automatic t_mvi();
        delay = 4'h0;
        mem_model_inst.ram[8'h20] = 8'hFF;
        mem_model_inst.ram[8'hFF] = 8'h77;
        run(opaddr_pkg::OP_MVI_LOAD, 8'h20);
        chk(acc, 8'h77);
        chk(mem_model_inst.ram[8'h20], 8'h00);
        run(opaddr_pkg::OP_MVI_STORE, 8'h20);
        chk(mem_model_inst.ram[8'h00], 8'h77);
        chk(mem_model_inst.ram[8'h20], 8'h01);
    endtask
    task automatic t_bad();
        run(8'h40, 8'h55);
        chk({7'h00, illegal_op}, 8'h01);
        chk(acc, 8'h77);
        run(opaddr_pkg::OP_MOV_A_IMM, 8'h3C);
        chk(acc, 8'h3C);
    endtask
    // Frozen only while idle: the memory model would count an ack the design never took
    task automatic t_hold();
        @(negedge clk);
        clk_en = 1'b0;
        prog_valid = 1'b1;
        prog_byte = opaddr_pkg::OP_MOV_X_IMM;
        repeat (3) @(negedge clk);
        prog_valid = 1'b0;
        clk_en = 1'b1;
        run(opaddr_pkg::OP_MOV_A_IMM, 8'h42);
        chk(acc, 8'h42);
        chk(idx, 8'h11);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk(flags, opaddr_pkg::FLAGS_RESET);
        chk(acc | idx | stack_pointer, 8'h00);
        t_imm();
        t_dir();
        t_dst();
        t_reg();
        t_mvi();
        t_bad();
        t_hold();
        close_out();
    end
endmodule
`default_nettype wire
